// ### rtl/ev_fault_pkg.sv
// Constants, register map and a helper function for the drive-fault interrupt logic
package ev_fault_pkg;

  localparam int unsigned ADDR_W        = 18;
  localparam logic [15:0] FRAME_BASE_A  = 16'h7400;
  localparam logic [15:0] FRAME_BASE_B  = 16'h7500;

  // Word index within the frame; byte address is four times the index
  localparam logic [5:0] IDX_COMPARE_CTRL = 6'h11;
  localparam logic [5:0] IDX_MASK_A       = 6'h2C;
  localparam logic [5:0] IDX_MASK_B       = 6'h2D;
  localparam logic [5:0] IDX_MASK_C       = 6'h2E;
  localparam logic [5:0] IDX_FLAG_A       = 6'h2F;
  localparam logic [5:0] IDX_FLAG_B       = 6'h30;
  localparam logic [5:0] IDX_FLAG_C       = 6'h31;
  localparam logic [5:0] IDX_FAULT_CFG    = 6'h3F;

  localparam int unsigned FAULT_STATUS_BIT = 8;
  localparam int unsigned FAULT_FLAG_BIT   = 0;
  localparam int unsigned QUAL_SEL_BIT     = 0;

  // Implemented flag bits per group and mask reset values
  localparam logic [15:0] IMPL_A     = 16'h07FF;
  localparam logic [15:0] IMPL_B     = 16'h000F;
  localparam logic [15:0] IMPL_C     = 16'h0007;
  localparam logic [15:0] MASK_RST_A = 16'h0001;
  localparam logic [15:0] MASK_RST_B = 16'h0000;
  localparam logic [15:0] MASK_RST_C = 16'h0000;

  localparam logic [15:0] CMP_CTRL_WMASK = 16'hFEFF;
  localparam logic [15:0] CMP_CTRL_RST   = 16'h0000;
  localparam logic        QUAL_LONG_RST  = 1'b0;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic [3:0]  QUAL_SHORT    = 4'h6;
  localparam logic [3:0]  QUAL_LONG     = 4'hC;

  // Byte-lane merge of a 16-bit register, limited to writable bits
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] wdata,
                                          input logic [1:0]  strb,
                                          input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_v & ~lane) | (wdata & lane);
  endfunction

endpackage

// ### rtl/fault_qualifier.sv
// Synchroniser and low-level qualifier for the drive-fault pin
`timescale 1ns/10ps
`default_nettype none
module fault_qualifier
  import ev_fault_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Pin and configuration
  input  wire logic drive_fault_input_n,
  input  wire logic qual_long,
  // Results
  output logic      pin_level,
  output logic      fault_pulse
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [3:0] cnt;
    logic       qualified;
    logic       pulse;
  } qual_t;

  qual_t st_r;
  qual_t st_nxt;
  logic [3:0] target;

  assign target = qual_long ? QUAL_LONG : QUAL_SHORT;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = drive_fault_input_n;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.pulse = 1'b0;
    if (st_r.sync2) begin
      st_nxt.cnt       = 4'h0;
      st_nxt.qualified = 1'b0;
    end else if (!st_r.qualified) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_r.cnt + 4'h1 >= target) begin
        st_nxt.qualified = 1'b1;
        st_nxt.pulse     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{sync1: 1'b1, sync2: 1'b1, cnt: 4'h0, qualified: 1'b0, pulse: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_level   = st_r.sync2;
  assign fault_pulse = st_r.pulse;

endmodule
`default_nettype wire

// ### rtl/irq_group.sv
// One interrupt group: sticky flags, mask register and group request
`timescale 1ns/10ps
`default_nettype none
module irq_group
  import ev_fault_pkg::*;
#(
  parameter logic [15:0] IMPL     = 16'h0001,
  parameter logic [15:0] MASK_RST = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Events
  input  wire logic [15:0] evt,
  // Register writes
  input  wire logic        wr_flag,
  input  wire logic        wr_mask,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  strb,
  // State
  output logic      [15:0] flags,
  output logic      [15:0] mask,
  output logic             req
);

  typedef struct packed {
    logic [15:0] flag;
    logic [15:0] mask;
  } grp_t;

  grp_t st_r;
  grp_t st_nxt;
  logic [15:0] w1c;

  always_comb begin
    st_nxt = st_r;
    w1c    = wr_flag ? merge16(16'h0000, wdata, strb, IMPL) : 16'h0000;
    st_nxt.flag = ((st_r.flag & ~w1c) | evt) & IMPL;
    if (wr_mask) begin
      st_nxt.mask = merge16(st_r.mask, wdata, strb, IMPL);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{flag: 16'h0000, mask: MASK_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flag;
  assign mask  = st_r.mask;
  assign req   = |(st_r.flag & st_r.mask);

endmodule
`default_nettype wire

// ### rtl/drive_fault_interrupt_logic.sv
// Drive-fault protection, event interrupt groups and APB register frame
`timescale 1ns/10ps
`default_nettype none
module drive_fault_interrupt_logic
  import ev_fault_pkg::*;
#(
  parameter logic [15:0] FRAME_BASE = FRAME_BASE_A
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Fault pin and PWM output enables
  input  wire logic              drive_fault_input_n,
  input  wire logic [7:0]        pwm_oe_in,
  output logic      [7:0]        pwm_oe,
  output logic                   pwm_hiz,
  // Event sources from timers, compare and capture units
  input  wire logic [15:0]       evt_a,
  input  wire logic [15:0]       evt_b,
  input  wire logic [15:0]       evt_c,
  // Compare control bits and interrupt requests
  output logic      [15:0]       cmp_ctrl,
  output logic      [2:0]        group_req,
  output logic                   irq
);

  typedef struct packed {
    logic [15:0] cmp_ctrl;
    logic        qual_long;
    logic        trip;
    logic [15:0] rdata;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  logic [5:0]  idx;
  logic        frame_hit;
  logic        wr_en;
  logic [15:0] wdata;
  logic [1:0]  strb;
  logic        pin_level;
  logic        fault_pulse;
  logic [15:0] evt_a_all;
  logic [15:0] flag_a, flag_b, flag_c;
  logic [15:0] mask_a, mask_b, mask_c;
  logic        fault_en;

  // Frame decode: external select plus upper word-address bits
  assign idx       = paddr[7:2];
  assign frame_hit = (paddr[ADDR_W-1:8] == FRAME_BASE[15:6]);
  assign wr_en     = psel && penable && pwrite && frame_hit;
  assign wdata     = pwdata[15:0];
  assign strb      = pstrb[1:0];

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !frame_hit;
  assign prdata  = {16'h0000, st_r.rdata};

  fault_qualifier u_qual (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .drive_fault_input_n (drive_fault_input_n),
    .qual_long           (st_r.qual_long),
    .pin_level           (pin_level),
    .fault_pulse         (fault_pulse)
  );

  // Fault flag sets regardless of its mask
  assign evt_a_all = evt_a | (fault_pulse ? 16'h0001 << FAULT_FLAG_BIT : 16'h0000);

  irq_group #(.IMPL(IMPL_A), .MASK_RST(MASK_RST_A)) u_grp_a (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .evt     (evt_a_all),
    .wr_flag (wr_en && idx == IDX_FLAG_A),
    .wr_mask (wr_en && idx == IDX_MASK_A),
    .wdata   (wdata),
    .strb    (strb),
    .flags   (flag_a),
    .mask    (mask_a),
    .req     (group_req[0])
  );

  irq_group #(.IMPL(IMPL_B), .MASK_RST(MASK_RST_B)) u_grp_b (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .evt     (evt_b),
    .wr_flag (wr_en && idx == IDX_FLAG_B),
    .wr_mask (wr_en && idx == IDX_MASK_B),
    .wdata   (wdata),
    .strb    (strb),
    .flags   (flag_b),
    .mask    (mask_b),
    .req     (group_req[1])
  );

  irq_group #(.IMPL(IMPL_C), .MASK_RST(MASK_RST_C)) u_grp_c (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .evt     (evt_c),
    .wr_flag (wr_en && idx == IDX_FLAG_C),
    .wr_mask (wr_en && idx == IDX_MASK_C),
    .wdata   (wdata),
    .strb    (strb),
    .flags   (flag_c),
    .mask    (mask_c),
    .req     (group_req[2])
  );

  assign irq = |group_req;

  // Tri-state is immediate on the raw pin, then held until the flag is cleared
  assign fault_en = mask_a[FAULT_FLAG_BIT];
  assign pwm_hiz  = fault_en && (!drive_fault_input_n || st_r.trip);
  assign pwm_oe   = pwm_hiz ? 8'h00 : pwm_oe_in;
  assign cmp_ctrl = st_r.cmp_ctrl;

  always_comb begin
    st_nxt = st_r;
    st_nxt.trip = (st_r.trip && flag_a[FAULT_FLAG_BIT]) || (fault_pulse && fault_en);
    if (wr_en && idx == IDX_COMPARE_CTRL) begin
      st_nxt.cmp_ctrl = merge16(st_r.cmp_ctrl, wdata, strb, CMP_CTRL_WMASK);
    end
    if (wr_en && idx == IDX_FAULT_CFG && strb[0]) begin
      st_nxt.qual_long = wdata[QUAL_SEL_BIT];
    end
    // Read data captured in the setup phase; undefined words read zero
    if (psel && !penable) begin
      case (idx)
        IDX_COMPARE_CTRL: st_nxt.rdata = (st_r.cmp_ctrl & CMP_CTRL_WMASK)
                                         | (16'(pin_level) << FAULT_STATUS_BIT);
        IDX_MASK_A:       st_nxt.rdata = mask_a;
        IDX_MASK_B:       st_nxt.rdata = mask_b;
        IDX_MASK_C:       st_nxt.rdata = mask_c;
        IDX_FLAG_A:       st_nxt.rdata = flag_a;
        IDX_FLAG_B:       st_nxt.rdata = flag_b;
        IDX_FLAG_C:       st_nxt.rdata = flag_c;
        IDX_FAULT_CFG:    st_nxt.rdata = 16'(st_r.qual_long) << QUAL_SEL_BIT;
        default:          st_nxt.rdata = 16'h0000;
      endcase
      if (!frame_hit) begin
        st_nxt.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{cmp_ctrl: CMP_CTRL_RST, qual_long: QUAL_LONG_RST, trip: 1'b0, rdata: 16'h0000};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// ### verification/drive_fault_checker.sv
// Port-level assertions for the drive-fault interrupt logic
`timescale 1ns/10ps
`default_nettype none
module drive_fault_checker
  import ev_fault_pkg::*;
#(
  parameter logic [15:0] FRAME_BASE = FRAME_BASE_A
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              nrst,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Fault path and requests
  input wire logic              drive_fault_input_n,
  input wire logic [7:0]        pwm_oe_in,
  input wire logic [7:0]        pwm_oe,
  input wire logic              pwm_hiz,
  input wire logic [2:0]        group_req,
  input wire logic              irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire logic hit = paddr[17:8] == FRAME_BASE[15:6];
  property p_oe_gate; pwm_hiz |-> pwm_oe == 8'h00; endproperty
  property p_oe_pass; !pwm_hiz |-> pwm_oe == pwm_oe_in; endproperty
  property p_hiz_cause; $rose(pwm_hiz) |-> !drive_fault_input_n; endproperty
  property p_irq_or; irq == (|group_req); endproperty
  property p_err; psel && penable && !pwrite && !hit |-> pslverr && prdata == 32'h0; endproperty
  property p_ok; psel && penable && hit |-> pready && !pslverr; endproperty
  property p_rd_hi; psel && penable |-> prdata[31:16] == 16'h0000; endproperty
  property p_req_fell; |($past(group_req) & ~group_req) |-> $past(psel && penable && pwrite);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pwm enables not cut");
  a_oe_pass: assert property (p_oe_pass) else $error("pwm enables altered");
  a_hiz_cause: assert property (p_hiz_cause) else $error("hiz without low pin");
  a_irq_or: assert property (p_irq_or) else $error("irq not group or");
  a_err: assert property (p_err) else $error("out of frame access taken");
  a_ok: assert property (p_ok) else $error("in frame access refused");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  a_req_fell: assert property (p_req_fell) else $error("request dropped alone");
  c_hiz: cover property (pwm_hiz);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule
bind drive_fault_interrupt_logic drive_fault_checker #(.FRAME_BASE(FRAME_BASE)) chk_i (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_fault_input_n(drive_fault_input_n), .pwm_oe_in(pwm_oe_in), .pwm_oe(pwm_oe),
  .pwm_hiz(pwm_hiz), .group_req(group_req), .irq(irq));
`default_nettype wire

// ### verification/irq_expander_model.sv
// Behavioural model of the interrupt expansion controller
`timescale 1ns/10ps
`default_nettype none
module irq_expander_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Requests and core acknowledge
  input  wire logic [2:0] req,
  input  wire logic       ack,
  // Core side
  output logic      [2:0] pend,
  output logic            cpu_int,
  output logic      [1:0] vector
);
  logic [2:0] top;
  // Lowest pending group wins
  assign top = pend & ~(pend - 3'h1);
  assign cpu_int = |pend;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend <= 3'h0;
      vector <= 2'h0;
    end else begin
      pend <= (pend | req) & ~(ack ? top : 3'h0);
      if (ack) vector <= top[0] ? 2'h1 : top[1] ? 2'h2 : {top[2], top[2]};
    end
  end
endmodule
`default_nettype wire

// ### verification/drive_fault_interrupt_logic_bench.sv
// Self-checking bench for the drive-fault interrupt logic
`timescale 1ns/10ps
`default_nettype none
module drive_fault_interrupt_logic_bench;
  import ev_fault_pkg::*;
  logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 1, ack = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, pwm_hiz, irq, cpu_int;
  logic [7:0]  oe_in, pwm_oe;
  logic [15:0] evt [3] = '{default: 16'h0};
  logic [15:0] cmp_ctrl, cmp_wr, d, m;
  logic [2:0]  group_req, pend;
  logic [1:0]  vector;
  logic [32:0] exp_q [$];
  int          fail_count = 0, cmp_count = 0, cyc = 0, n;
  always #50 clk_sys = ~clk_sys;
  drive_fault_interrupt_logic dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_fault_input_n(pin_n),
    .pwm_oe_in(oe_in), .pwm_oe(pwm_oe), .pwm_hiz(pwm_hiz), .evt_a(evt[0]), .evt_b(evt[1]),
    .evt_c(evt[2]), .cmp_ctrl(cmp_ctrl), .group_req(group_req), .irq(irq));
  irq_expander_model interrupt_expansion_controller (.clk_sys(clk_sys), .nrst(nrst), .req(group_req), .ack(ack),
    .pend(pend), .cpu_int(cpu_int), .vector(vector));
  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [32:0] e, input logic [32:0] g, input string nm);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] v,
                      input logic [32:0] e);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, v};
    pstrb <= 4'hF;
    if (!w) exp_q.push_back(e);
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] v);
    xfer(1, {FRAME_BASE_A[15:6], i, 2'b00}, v, 33'h0);
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    xfer(0, {FRAME_BASE_A[15:6], i, 2'b00}, 16'h0, {17'h0, e});
  endtask
  // Read results are matched against the oldest expectation
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk(exp_q.pop_front(), {pslverr, prdata}, "rdata");
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(91));
    oe_in <= 8'($urandom);
    repeat (3) @(posedge clk_sys);
    nrst <= 1;
    rd(IDX_MASK_A, MASK_RST_A);
    rd(IDX_MASK_B, MASK_RST_B);
    rd(IDX_COMPARE_CTRL, 16'h0100);
    cmp_wr = 16'($urandom);
    wr(IDX_COMPARE_CTRL, cmp_wr);
    #1 chk(cmp_wr & CMP_CTRL_WMASK, cmp_ctrl, "cmp_ctrl");
    rd(IDX_COMPARE_CTRL, (cmp_wr & CMP_CTRL_WMASK) | 16'h0100);
    wr(6'h01, cmp_wr);
    rd(6'h01, 16'h0);
    xfer(0, {FRAME_BASE_B[15:6], IDX_MASK_A, 2'b00}, 16'h0, {1'b1, 32'h0});
    for (int g = 0; g < 3; g++) begin
      m = g == 0 ? IMPL_A & 16'hFFFE : g == 1 ? IMPL_B : IMPL_C;
      do n = $urandom_range(15); while (!m[n]);
      d = 16'h1 << n;
      @(posedge clk_sys) evt[g] <= d;
      @(posedge clk_sys) evt[g] <= 16'h0;
      rd(6'(IDX_FLAG_A + g), d);
      #1 chk(0, group_req[g], "req");
      wr(6'(IDX_MASK_A + g), d);
      #1 chk(1, group_req[g], "req");
      chk(1, irq, "irq");
      @(posedge clk_sys) ack <= 1;
      @(posedge clk_sys) ack <= 0;
      #1 chk(g + 1, vector, "vector");
      // Event pulse lands exactly on the access edge of the clearing write
      fork
        wr(6'(IDX_FLAG_A + g), d);
        begin
          repeat (2) @(posedge clk_sys);
          evt[g] <= d;
          @(posedge clk_sys) evt[g] <= 16'h0;
        end
      join
      rd(6'(IDX_FLAG_A + g), d);
      wr(6'(IDX_FLAG_A + g), 16'h0);
      rd(6'(IDX_FLAG_A + g), d);
      wr(6'(IDX_FLAG_A + g), d);
      rd(6'(IDX_FLAG_A + g), 16'h0);
      #1 chk(0, group_req[g], "req");
      wr(6'(IDX_MASK_A + g), g == 0 ? MASK_RST_A : 16'h0);
      // Drain the request latched while the flag was still set
      @(posedge clk_sys) ack <= 1;
      @(posedge clk_sys) ack <= 0;
      #1 chk(0, cpu_int, "cpu_int");
    end
    // Pass 0 short window, pass 1 long window, pass 2 masked
    for (int k = 0; k < 3; k++) begin
      wr(IDX_FAULT_CFG, 16'(k == 1));
      if (k == 2) wr(IDX_MASK_A, 16'h0);
      @(posedge clk_sys) pin_n <= 0;
      #1 chk(k < 2, pwm_hiz, "hiz");
      chk(k < 2 ? 8'h0 : oe_in, pwm_oe, "oe");
      repeat (4) @(posedge clk_sys);
      pin_n <= 1;
      #1 chk(0, pwm_hiz, "hiz");
      repeat (5) @(posedge clk_sys);
      pin_n <= 0;
      n = 0;
      while (group_req[0] !== 1'b1 && n < 30) begin
        @(posedge clk_sys);
        #1 n++;
      end
      m = k == 1 ? 16'(QUAL_LONG) : 16'(QUAL_SHORT);
      chk(k < 2, n >= m + SYNC_STAGES && n <= m + SYNC_STAGES + 3, "delay");
      rd(IDX_FLAG_A, 16'h0001);
      rd(IDX_COMPARE_CTRL, cmp_wr & CMP_CTRL_WMASK);
      pin_n <= 1;
      #1 chk(k < 2, pwm_hiz, "hiz");
      wr(IDX_FLAG_A, 16'h0001);
      @(posedge clk_sys);
      #1 chk(0, pwm_hiz, "hiz");
    end
    finish_test;
  end
endmodule
`default_nettype wire
